// [rtc_lf_model.sv]
// Tick source and interrupt-side pulse counter facing the periodic counter
`timescale 1ns/100ps
module rtc_lf_model (
  input  wire logic        clk_i,     // System clock
  input  wire logic        rst_i,     // Synchronous reset
  input  wire logic        tick_en_i, // Oscillator ticking
  input  wire logic        pulse_i,   // Interval pulse
  output logic             lf_tick_o, // Tick each cycle when enabled
  output logic      [15:0] pulse_n_o  // Pulses taken
);
  // Ticks at the fastest rate the counter accepts
  always_ff @(posedge clk_i) begin
    lf_tick_o <= tick_en_i && !rst_i;
  end
  // One event per high cycle, so a long pulse counts once for each cycle it is high
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pulse_n_o <= 16'h0000;
    end else if (pulse_i) begin
      pulse_n_o <= pulse_n_o + 16'h0001;
    end
  end
endmodule

// [rtc_period_counter.sv]
// Binary up-counter that wraps at the selected interval
`timescale 1ns/100ps
module rtc_period_counter
  import rtc_pkg::*;
(
  input  wire logic        clk_i,     // System clock
  input  wire logic        rst_i,     // Synchronous reset, active high
  input  wire logic        clear_i,   // Return count to zero
  input  wire logic        count_i,   // Advance on this cycle
  input  wire logic [1:0]  sel_i,     // Period select code
  output logic      [13:0] count_o,   // Current count
  output logic             wrap_o     // One-cycle pulse at end of interval
);

  logic at_end;

  // End of the chosen interval
  assign at_end = (count_o == rtc_terminal(sel_i)); // [RULE3] [RULE12]

  // Count up on each tick, clear at the interval end and carry on
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      count_o <= 14'h0000;
    end else if (count_i) begin
      if (at_end) begin
        count_o <= 14'h0000; // [RULE2]
      end else begin
        count_o <= count_o + 14'h0001; // [RULE1]
      end
    end
  end

  // Flag the end of each interval for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i || clear_i) begin
      wrap_o <= 1'b0;
    end else begin
      wrap_o <= count_i && at_end; // [RULE2]
    end
  end

endmodule

// [rtc_periodic.sv]
// Periodic real-time counter with Wishbone register access
//
// Notes on behaviour
// RULE1: Counter advances once per low-frequency tick while the run bit is one.
// RULE2: At interval end raise interrupt, clear counter, keep counting without pause.
// RULE3: Four intervals: 0.0625 s, 0.125 s, 0.25 s and 0.5 s.
// RULE4: Counts in every power mode with oscillator on, except stop and deepest sleep.
// RULE5: Software writes control only while the oscillator enable bit is one.
// RULE6: Software changes period select only while stopped, not in the stopping write.
// RULE7: Oscillator enable cleared while running stops counter, resets control and count.
// RULE8: Entering stop or deepest sleep while running reinitialises control and count.
// RULE9: After stop or deepest sleep, software reprograms control before restarting.
// RULE10: Control read returns bits 7 to 3 without meaning; here zero.
// RULE11: Debugger break freezes count and control; resumes from the same count.
// RULE12: Two-bit select, ascending codes pick longest to shortest; counter wide enough.
// RULE13: Interrupt request leaves as a single-cycle pulse in the system clock domain.
//
// The Wishbone interface to the registers and the register offsets were left to the implementer.
`timescale 1ns/100ps
module rtc_periodic
  import rtc_pkg::*;
(
  input  wire logic        clk_i,                // System clock, 25 MHz
  input  wire logic        rst_i,                // Synchronous reset, active high
  input  wire logic        wb_cyc_i,             // Wishbone cycle
  input  wire logic        wb_stb_i,             // Wishbone strobe
  input  wire logic        wb_we_i,              // Wishbone write enable
  input  wire logic [7:0]  wb_adr_i,             // Wishbone byte address
  input  wire logic [3:0]  wb_sel_i,             // Wishbone byte lanes
  input  wire logic [31:0] wb_dat_i,             // Wishbone write data
  output logic      [31:0] wb_dat_o,             // Wishbone read data
  output logic             wb_ack_o,             // Wishbone acknowledge
  input  wire logic        lf_tick_i,            // Low-frequency clock tick, one cycle
  input  wire logic        stop_mode_i,          // Chip entering stop mode
  input  wire logic        deepest_sleep_mode_i, // Chip entering deepest sleep
  input  wire logic        debug_break_i,        // Debugger break in progress
  output logic             periodic_tick_irq_o,  // Interval interrupt pulse
  output logic             irq_o,                // Level interrupt from status and mask
  output logic             running_o             // Counter is counting
);

  rtc_ctrl_t   rtc_control_reg;
  logic        low_freq_osc_enable;
  logic [1:0]  status;
  logic [1:0]  mask;
  rtc_state_t  state;
  rtc_state_t  next_state;
  logic [13:0] count;
  logic        wrap;
  logic        osc_prev;
  logic        req;
  logic        wr_fire;
  logic        lane0;
  logic        hit_ctrl;
  logic        hit_sys;
  logic        hit_status;
  logic        hit_mask;
  logic        hit_count;
  logic        osc_dropped;
  logic        mode_stop;
  logic        autostop;
  logic        counting;
  logic [1:0]  ev_set;
  logic [31:0] rd_data;

  // Bus request decode; a write lands at the edge where ack is seen
  assign req        = wb_cyc_i && wb_stb_i;
  assign wr_fire    = req && wb_we_i && wb_ack_o;
  assign lane0      = wb_sel_i[0];
  assign hit_ctrl   = (wb_adr_i == `RTC_OFS_CTRL);
  assign hit_sys    = (wb_adr_i == `RTC_OFS_SYSCTL2);
  assign hit_status = (wb_adr_i == `RTC_OFS_STATUS);
  assign hit_mask   = (wb_adr_i == `RTC_OFS_MASK);
  assign hit_count  = (wb_adr_i == `RTC_OFS_COUNT);

  // Conditions that force the counter to stop and reinitialise
  assign osc_dropped = osc_prev && !low_freq_osc_enable;
  assign mode_stop   = stop_mode_i || deepest_sleep_mode_i; // [RULE4]
  assign autostop    = (state != RTC_ST_STOP) && (osc_dropped || mode_stop); // [RULE7] [RULE8]

  // Advance only while running, not frozen, not being shut down
  assign counting = (state == RTC_ST_RUN) && lf_tick_i && !autostop; // [RULE1] [RULE11]

  // Events that set status bits
  assign ev_set[`RTC_EV_PERIOD]   = wrap;
  assign ev_set[`RTC_EV_AUTOSTOP] = autostop;

  // Single acknowledge per request, dropped the cycle after
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= req && !wb_ack_o;
    end
  end

  // Read multiplexer; unmapped addresses read zero
  always_comb begin
    rd_data = 32'h0000_0000;
    if (hit_ctrl) begin
      rd_data[2:0] = rtc_control_reg; // [RULE10]
    end else if (hit_sys) begin
      rd_data[`RTC_SYS_OSC_BIT] = low_freq_osc_enable;
    end else if (hit_status) begin
      rd_data[1:0] = status;
    end else if (hit_mask) begin
      rd_data[1:0] = mask;
    end else if (hit_count) begin
      rd_data[13:0] = count;
    end
  end

  // Read data captured alongside ack
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_dat_o <= 32'h0000_0000;
    end else if (req && !wb_ack_o && !wb_we_i) begin
      wb_dat_o <= rd_data;
    end
  end

  // Oscillator enable held in the second system control register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      low_freq_osc_enable <= `RTC_SYSCTL_RESET;
    end else if (wr_fire && hit_sys && lane0) begin
      low_freq_osc_enable <= wb_dat_i[`RTC_SYS_OSC_BIT];
    end
  end

  // Previous oscillator enable, for spotting the falling edge
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      osc_prev <= 1'b0;
    end else begin
      osc_prev <= low_freq_osc_enable;
    end
  end

  // Control register; automatic stop wins over a write
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rtc_control_reg <= `RTC_CTRL_RESET;
    end else if (autostop) begin
      rtc_control_reg <= `RTC_CTRL_RESET; // [RULE7] [RULE8]
    end else if (wr_fire && hit_ctrl && lane0) begin
      // Software keeps the select steady while running and only writes with oscillator on
      rtc_control_reg.run <= wb_dat_i[`RTC_CTRL_RUN_BIT]; // [RULE5] [RULE6] [RULE9]
      rtc_control_reg.sel <= wb_dat_i[`RTC_CTRL_SEL_MSB:`RTC_CTRL_SEL_LSB];
    end
  end

  // Run state follows the run bit, the break input and forced stops
  always_comb begin
    next_state = state;
    unique case (state)
      RTC_ST_STOP: begin
        if (rtc_control_reg.run && !autostop) begin
          next_state = RTC_ST_RUN;
        end
      end
      RTC_ST_RUN: begin
        if (autostop || !rtc_control_reg.run) begin
          next_state = RTC_ST_STOP;
        end else if (debug_break_i) begin
          next_state = RTC_ST_HALT; // [RULE11]
        end
      end
      RTC_ST_HALT: begin
        if (autostop || !rtc_control_reg.run) begin
          next_state = RTC_ST_STOP;
        end else if (!debug_break_i) begin
          next_state = RTC_ST_RUN; // [RULE11]
        end
      end
      default: begin
        next_state = RTC_ST_STOP;
      end
    endcase
  end

  // State register
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state <= RTC_ST_STOP;
    end else begin
      state <= next_state;
    end
  end

  // Counter is cleared on a forced stop and while the run bit is zero
  rtc_period_counter u_counter (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .clear_i (autostop || !rtc_control_reg.run), // [RULE7] [RULE8]
    .count_i (counting),
    .sel_i   (rtc_control_reg.sel),
    .count_o (count),
    .wrap_o  (wrap)
  );

  // Interval interrupt as a one-cycle pulse on the system clock
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      periodic_tick_irq_o <= 1'b0;
    end else begin
      periodic_tick_irq_o <= wrap; // [RULE2] [RULE13]
    end
  end

  // Sticky status; a new event wins over a write-one clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      status <= `RTC_EV_RESET;
    end else if (wr_fire && hit_status && lane0) begin
      status <= (status & ~wb_dat_i[1:0]) | ev_set;
    end else begin
      status <= status | ev_set;
    end
  end

  // Interrupt mask, same layout as status
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      mask <= `RTC_EV_RESET;
    end else if (wr_fire && hit_mask && lane0) begin
      mask <= wb_dat_i[1:0];
    end
  end

  // Level interrupt while any unmasked status bit stands
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else begin
      irq_o <= |(status & mask);
    end
  end

  // Visible run indicator
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      running_o <= 1'b0;
    end else begin
      running_o <= (next_state == RTC_ST_RUN);
    end
  end

endmodule

// [rtc_periodic_sva.sv]
// Port checks of the periodic counter
`timescale 1ns/100ps
module rtc_periodic_sva (
  input wire logic        clk_i,                // Clock
  input wire logic        rst_i,                // Reset
  input wire logic        wb_cyc_i,             // Cycle
  input wire logic        wb_stb_i,             // Strobe
  input wire logic        wb_we_i,              // Write
  input wire logic [7:0]  wb_adr_i,             // Address
  input wire logic [31:0] wb_dat_o,             // Read data
  input wire logic        wb_ack_o,             // Ack
  input wire logic        lf_tick_i,            // Tick
  input wire logic        stop_mode_i,          // Stop
  input wire logic        deepest_sleep_mode_i, // Deepest sleep
  input wire logic        debug_break_i,        // Break
  input wire logic        periodic_tick_irq_o,  // Interval pulse
  input wire logic        running_o             // Counting
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  logic [15:0] tick_gap;
  // Ticks since the last pulse, saturating
  always_ff @(posedge clk_i) begin
    if (rst_i || periodic_tick_irq_o) begin
      tick_gap <= 16'h0000;
    end else if (lf_tick_i && tick_gap != 16'hFFFF) begin
      tick_gap <= tick_gap + 16'h0001;
    end
  end
  sequence s_req; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
  sequence s_brk; debug_break_i [*5]; endsequence
  sequence s_idle; !running_o [*6]; endsequence
  property p_ack; s_req |=> wb_ack_o; endproperty
  property p_pulse; periodic_tick_irq_o |=> !periodic_tick_irq_o; endproperty
  property p_gap; periodic_tick_irq_o |-> tick_gap >= 16'h07F8; endproperty
  property p_brk; s_brk |-> !running_o && !periodic_tick_irq_o; endproperty
  property p_stop; stop_mode_i |-> ##[1:2] !running_o; endproperty
  property p_sleep; deepest_sleep_mode_i |-> ##[1:2] !running_o; endproperty
  property p_idle; s_idle |-> !periodic_tick_irq_o; endproperty
  property p_upper; wb_ack_o && !wb_we_i && wb_adr_i == 8'h00 |-> wb_dat_o[31:3] == 29'h0;
  endproperty
  a_ack: assert property (p_ack) else $error("late ack");
  a_pulse: assert property (p_pulse) else $error("pulse too long");
  a_gap: assert property (p_gap) else $error("interval short");
  a_brk: assert property (p_brk) else $error("counting in break");
  a_stop: assert property (p_stop) else $error("stop ignored");
  a_sleep: assert property (p_sleep) else $error("sleep ignored");
  a_idle: assert property (p_idle) else $error("pulse while stopped");
  a_upper: assert property (p_upper) else $error("control high bits set");
endmodule
bind rtc_periodic rtc_periodic_sva u_sva (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_dat_o(wb_dat_o),
  .wb_ack_o(wb_ack_o), .lf_tick_i(lf_tick_i), .stop_mode_i(stop_mode_i),
  .deepest_sleep_mode_i(deepest_sleep_mode_i), .debug_break_i(debug_break_i),
  .periodic_tick_irq_o(periodic_tick_irq_o), .running_o(running_o));

// [rtc_pkg.sv]
// Types and shared functions of the periodic counter
package rtc_pkg;
  `include "rtc_regs.svh"

  // Control register contents
  typedef struct packed {
    logic [1:0] sel;  // Period select field
    logic       run;  // Counter run bit
  } rtc_ctrl_t;

  // Run state of the counter
  typedef enum logic [2:0] {
    RTC_ST_STOP = 3'b001,
    RTC_ST_RUN  = 3'b010,
    RTC_ST_HALT = 3'b100
  } rtc_state_t;

  // Terminal count of the binary counter for a period select code
  function automatic logic [13:0] rtc_terminal(input logic [1:0] sel);
    logic [63:0] ticks;
    ticks = `RTC_TICKS(`RTC_PER_SEL0_US);
    unique case (sel)
      2'h0: ticks = `RTC_TICKS(`RTC_PER_SEL0_US);
      2'h1: ticks = `RTC_TICKS(`RTC_PER_SEL1_US);
      2'h2: ticks = `RTC_TICKS(`RTC_PER_SEL2_US);
      2'h3: ticks = `RTC_TICKS(`RTC_PER_SEL3_US);
    endcase
    return 14'(ticks - 64'd1);
  endfunction
endpackage

// [rtc_regs.svh]
// Register offsets, field positions, reset values and timing counts of the periodic counter
`ifndef RTC_REGS_SVH
`define RTC_REGS_SVH

// Byte offsets on the register bus
`define RTC_OFS_CTRL      8'h00
`define RTC_OFS_SYSCTL2   8'h04
`define RTC_OFS_STATUS    8'h08
`define RTC_OFS_MASK      8'h0C
`define RTC_OFS_COUNT     8'h10

// Control register fields
`define RTC_CTRL_RUN_BIT  0
`define RTC_CTRL_SEL_LSB  1
`define RTC_CTRL_SEL_MSB  2
`define RTC_CTRL_RESET    3'h0

// System control two fields
`define RTC_SYS_OSC_BIT   0
`define RTC_SYSCTL_RESET  1'h0

// Status and mask fields
`define RTC_EV_PERIOD     0
`define RTC_EV_AUTOSTOP   1
`define RTC_EV_RESET      2'h0

// Low-frequency tick rate and the four intervals in microseconds
`define RTC_LF_HZ         64'd32768
`define RTC_US_PER_S      64'd1000000
`define RTC_PER_SEL0_US   64'd500000
`define RTC_PER_SEL1_US   64'd250000
`define RTC_PER_SEL2_US   64'd125000
`define RTC_PER_SEL3_US   64'd62500

// Whole low-frequency ticks in an interval, rounded down
`define RTC_TICKS(us)     (((us) * `RTC_LF_HZ) / `RTC_US_PER_S)

`endif

// [tb.sv]
// Self-checking bench of the periodic counter
`timescale 1ns/100ps
module tb;
  logic        clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, ten = 0;
  logic        stp = 0, slp = 0, brk = 0, ack, pirq, irq, run, tick;
  logic [3:0]  sel = 4'hF;
  logic [7:0]  adr = 8'h00;
  logic [15:0] pn, p;
  logic [31:0] wdat = 32'h0, rdat, q, c1;
  int          n_mismatch = 0, cmp_count = 0, cycles = 0, n;
  always #20 clk_i = ~clk_i;
  rtc_periodic dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
    .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
    .lf_tick_i(tick), .stop_mode_i(stp), .deepest_sleep_mode_i(slp), .debug_break_i(brk),
    .periodic_tick_irq_o(pirq), .irq_o(irq), .running_o(run));
  rtc_lf_model far (.clk_i(clk_i), .rst_i(rst_i), .tick_en_i(ten), .pulse_i(pirq),
    .lf_tick_o(tick), .pulse_n_o(pn));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // Classic single Wishbone cycle, held until ack is sampled
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_i);
      k++;
    end while (ack !== 1'b1 && k < 20);
    q = rdat;
    if (k >= 20) begin
      n_mismatch++;
      $display("[ERR] %0t no ack from bus", $time);
    end
    cyc <= 1'b0;
    stb <= 1'b0;
    we <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a); xfer(1'b0, a, 32'h0); endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d); xfer(1'b1, a, d); endtask
  // Cycles until the interrupt side takes the next pulse
  task automatic wait_pulse;
    p = pn;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (pn === p && n < 20000);
    if (n >= 20000) begin
      n_mismatch++;
      $display("[ERR] %0t no interval pulse", $time);
    end
  endtask
  task automatic conclude;
    $display("compares %0d mismatches %0d", cmp_count, n_mismatch);
    if (n_mismatch == 0 && cmp_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  // Hang guard
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 90000) begin
      n_mismatch++;
      $display("[ERR] %0t run limit reached", $time);
      conclude;
    end
  end
  // Main sequence
  initial begin
    repeat (6) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 24; a += 4) begin
      rd(8'(a));
      chk(q, 32'h0);
    end
    $display("test reset done");
    wr(8'h04, 32'h1);
    wr(8'h0C, 32'h1);
    for (int s = 0; s < 4; s++) begin
      wr(8'h00, 32'(s << 1));
      wr(8'h00, 32'(s << 1 | 1));
      rd(8'h00);
      chk(q, 32'(s << 1 | 1));
      ten <= 1'b1;
      wait_pulse;
      wait_pulse;
      chk(32'(n), 32'(32768 >> (s + 1)));
      ten <= 1'b0;
      wr(8'h00, 32'(s << 1));
      chk({31'h0, irq}, 32'h1);
      wr(8'h08, 32'h1);
      rd(8'h08);
      chk({31'h0, irq}, 32'h0);
    end
    chk({16'h0, pn}, 32'h8);
    $display("test periods done");
    wr(8'h00, 32'h7);
    ten <= 1'b1;
    repeat (50) @(posedge clk_i);
    ten <= 1'b0;
    repeat (3) @(posedge clk_i);
    rd(8'h10);
    c1 = q;
    brk <= 1'b1;
    ten <= 1'b1;
    repeat (30) @(posedge clk_i);
    ten <= 1'b0;
    rd(8'h10);
    chk(q, c1);
    brk <= 1'b0;
    rd(8'h10);
    chk(q, c1);
    rd(8'h00);
    chk(q, 32'h7);
    chk({31'h0, run}, 32'h1);
    $display("test break done");
    for (int k = 0; k < 3; k++) begin
      wr(8'h00, 32'h7);
      ten <= 1'b1;
      repeat (20) @(posedge clk_i);
      if (k == 0) stp <= 1'b1;
      if (k == 1) slp <= 1'b1;
      if (k == 2) wr(8'h04, 32'h0);
      repeat (2) @(posedge clk_i);
      stp <= 1'b0;
      slp <= 1'b0;
      ten <= 1'b0;
      rd(8'h00);
      chk(q, 32'h0);
      rd(8'h10);
      chk(q, 32'h0);
      rd(8'h08);
      chk(q & 32'h2, 32'h2);
      chk({31'h0, run}, 32'h0);
      wr(8'h08, 32'h3);
      wr(8'h04, 32'h1);
    end
    $display("test forced stop done");
    conclude;
  end
endmodule
